// ### bench/fcs_flash_sequencer_chk.sv
`timescale 1ns/1ps
// checker on the sequencer's ports
module fcs_flash_sequencer_chk
    import fcs_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire fcs_req_s reg_req,
    input wire logic [7:0] reg_rdata,
    input wire logic [10:0] die_temp_sample,
    input wire logic wake_cond_met,
    input wire logic single_wire_host_line,
    input wire logic sleep_mode,
    input wire logic cmd_busy
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    logic cmd_wr; // command write taken while idle
    assign cmd_wr = reg_req.wr && reg_req.addr == 7'h62 && !cmd_busy;
    logic erase_wr; // page erase command taken
    assign erase_wr = cmd_wr && reg_req.wdata inside {8'h40, 8'h41, 8'h42};
    temp_low_a: assert property (
        $past(reg_req.rd && reg_req.addr == 7'h60) && $past(die_temp_sample, 2) ==
        $past(die_temp_sample) |-> reg_rdata == $past(die_temp_sample[7:0]))
        else $error("low temperature byte wrong");
    temp_high_a: assert property (
        $past(reg_req.rd && reg_req.addr == 7'h61) && $past(die_temp_sample, 2) ==
        $past(die_temp_sample) |-> reg_rdata == {5'h00, $past(die_temp_sample[10:8])})
        else $error("high temperature bits wrong");
    cmd_busy_a: assert property (cmd_wr && reg_req.wdata == 8'h40 |=> cmd_busy)
        else $error("command did not start");
    erase_end_a: assert property (erase_wr |-> ##[32:38] !cmd_busy)
        else $error("erase did not finish in time");
    erase_busy_a: assert property (erase_wr |=> cmd_busy [*8])
        else $error("erase ended early");
    sleep_cmd_a: assert property (sleep_mode |-> cmd_busy)
        else $error("asleep with no command pending");
    sleep_hold_a: assert property (
        sleep_mode && $stable(single_wire_host_line) && $past(single_wire_host_line, 4) ==
        single_wire_host_line && $past(single_wire_host_line, 2) == single_wire_host_line &&
        $past(single_wire_host_line, 3) == single_wire_host_line
        |=> sleep_mode) else $error("left sleep without line edge");
    wake_edge_a: assert property (
        sleep_mode && $changed(single_wire_host_line) |-> ##[1:6] !sleep_mode)
        else $error("line edge did not wake");
endmodule // fcs_flash_sequencer_chk

bind fcs_flash_sequencer fcs_flash_sequencer_chk i_chk(.core_clk(core_clk), .resetn(resetn),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .die_temp_sample(die_temp_sample),
    .wake_cond_met(wake_cond_met), .single_wire_host_line(single_wire_host_line),
    .sleep_mode(sleep_mode), .cmd_busy(cmd_busy));

// ### bench/fcs_host_model.sv
`timescale 1ns/1ps
// host side of the single-wire line
module fcs_host_model
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic toggle,
    output logic line
);
    // line is set high by reset; each request flips it once
    // wake edge source
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            line <= 1'b1;
        else if (toggle)
            line <= ~line;
    end
endmodule // fcs_host_model

// ### bench/testbench.sv
`timescale 1ns/1ps
module testbench;
    import fcs_pkg::*;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    fcs_req_s req = '0;
    logic [7:0] rdata;
    logic [10:0] temp = 11'h5A3;
    logic wake_met = 1'b0;
    logic toggle = 1'b0;
    logic line;
    logic sleep_mode;
    logic busy;
    int failures = 0;
    int num_checks = 0;
    logic [7:0] d;
    logic [7:0] codes [7] = '{8'h0F, 8'h40, 8'h41, 8'h42, 8'h45, 8'h48, 8'h33};
    always #12.5 core_clk = ~core_clk;
    fcs_flash_sequencer i_dut(.core_clk(core_clk), .resetn(resetn), .reg_req(req),
        .reg_rdata(rdata), .die_temp_sample(temp), .wake_cond_met(wake_met),
        .single_wire_host_line(line), .sleep_mode(sleep_mode), .cmd_busy(busy));
    fcs_host_model i_host(.core_clk(core_clk), .resetn(resetn), .toggle(toggle), .line(line));
    // verdict and end of run
    task stop_test;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // compare seen against expected
    task chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one-cycle register write
    task wr(input logic [6:0] a, input logic [7:0] v);
        @(posedge core_clk) req <= {a, v, 1'b1, 1'b0};
        @(posedge core_clk) req.wr <= 1'b0;
    endtask
    // one-cycle read, data in the next cycle
    task rd(input logic [6:0] a, output logic [7:0] v);
        @(posedge core_clk) req <= {a, 8'h00, 1'b0, 1'b1};
        @(posedge core_clk) req.rd <= 1'b0;
        @(posedge core_clk) v = rdata;
    endtask
    // poll command register until it clears
    task wait_idle;
        int n;
        n = 0;
        d = 8'hFF;
        while (d !== 8'h00 && n < 100)
        begin
            rd(7'h62, d);
            n++;
        end
        chk(d, 8'h00);
        chk({7'h00, busy}, 8'h00);
    endtask
    task tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // one edge on the host line
    task flip;
        toggle <= 1'b1;
        tick(1);
        toggle <= 1'b0;
    endtask
    // main sequence
    initial
    begin
        repeat (3) @(posedge core_clk);
        resetn <= 1'b1;
        rd(7'h72, d); chk(d, 8'h07);
        rd(7'h62, d); chk(d, 8'h00);
        rd(7'h10, d); chk(d, 8'h00);
        wr(7'h60, 8'h00); rd(7'h60, d); chk(d, 8'hA3);
        rd(7'h61, d); chk(d, 8'h05);
        temp <= 11'h7FF;
        rd(7'h61, d); chk(d & 8'h07, 8'h07);
        rd(7'h60, d); chk(d, 8'hFF);
        wr(7'h70, 8'h5F);
        wr(7'h71, 8'h3C);
        foreach (codes[i])
        begin
            wr(7'h62, codes[i]);
            if (codes[i] inside {8'h40, 8'h41, 8'h42, 8'h45, 8'h48})
            begin
                rd(7'h62, d); chk(d, codes[i]);
                chk({7'h00, busy}, 8'h01);
            end
            wait_idle();
        end
        // write during an erase is dropped
        wr(7'h62, 8'h40);
        wr(7'h70, 8'h11);
        wait_idle();
        rd(7'h70, d); chk(d, 8'h5F);
        // power-down waits for the wake condition
        wr(7'h62, 8'hF6);
        tick(20);
        chk({7'h00, sleep_mode}, 8'h00);
        wake_met <= 1'b1;
        tick(8);
        chk({7'h00, sleep_mode}, 8'h01);
        tick(10);
        flip();
        tick(8);
        chk({7'h00, sleep_mode}, 8'h00);
        wait_idle();
        // zero threshold means immediate sleep
        wake_met <= 1'b0;
        wr(7'h72, 8'h00);
        wr(7'h62, 8'hF6);
        tick(6);
        chk({7'h00, sleep_mode}, 8'h01);
        flip();
        tick(8);
        chk({7'h00, sleep_mode}, 8'h00);
        wait_idle();
        stop_test();
    end
    // watchdog against a hang
    initial
    begin
        #1_000_000;
        failures++;
        stop_test();
    end
endmodule // testbench

// ### rtl/fcs_defines.svh
`ifndef FCS_DEFINES_SVH
`define FCS_DEFINES_SVH

// register offsets on the plain register port
`define FCS_OFS_TEMP_LOW 7'h60
`define FCS_OFS_TEMP_HIGH 7'h61
`define FCS_OFS_CMD 7'h62
`define FCS_OFS_PROG_ADDR 7'h70
`define FCS_OFS_PROG_DATA 7'h71
`define FCS_OFS_WAKE_SEL 7'h72
`define FCS_OFS_STATUS 7'h73

// command codes
`define FCS_CMD_PROG_BYTE 8'h0F
`define FCS_CMD_ERASE_P0 8'h40
`define FCS_CMD_ERASE_P1 8'h41
`define FCS_CMD_ERASE_P2 8'h42
`define FCS_CMD_RAM_TO_FLASH 8'h45
`define FCS_CMD_FLASH_TO_RAM 8'h48
`define FCS_CMD_POWER_DOWN 8'hF6

// field positions and reset values
`define FCS_TEMP_HIGH_MSB 2
`define FCS_WAKE_SEL_RESET 3'h7
`define FCS_ERASED_BYTE 8'hFF
`define FCS_PAGE_LAST 5'h1F
`define FCS_LINE_SYNC_RESET 2'h3
`define FCS_LINE_LAST_RESET 1'h1

`endif

// ### rtl/fcs_flash_sequencer.sv
`timescale 1ns/1ps
`include "fcs_defines.svh"
// Summary of operation
// RULE_01: written command code selects the operation
// RULE_02: command register clears when operation completes
// RULE_03: program byte ANDs data into addressed byte
// RULE_04: erase page 0 clears bytes 0x00-0x1F
// RULE_05: erase page 1 clears bytes 0x20-0x3F
// RULE_06: erase page 2 clears bytes 0x40-0x5F
// RULE_07: RAM copied into flash page 0 (code ANDs each RAM byte into the old page 0 byte)
// RULE_08: flash page 0 copied into RAM
// RULE_09: power-down sleeps once wake condition met
// RULE_10: sleep ends on any host line edge
// RULE_11: temperature is 11-bit quarter-kelvin value
// RULE_12: temperature is high[2:0] then low[7:0]
// RULE_13: reserved high bits read zero after reset
// RULE_14: host masks reserved high temperature bits
// RULE_15: wake bits reset ones; zero means immediate sleep
// RULE_16: host waits for zero command before next
module fcs_flash_sequencer
    import fcs_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    // register port
    input wire fcs_req_s reg_req,
    output logic [7:0] reg_rdata,
    // die temperature sample from the converter
    input wire logic [10:0] die_temp_sample,
    // sense-voltage-below-threshold from the analog front end, asynchronous
    input wire logic wake_cond_met,
    // single-wire host line, asynchronous pin
    input wire logic single_wire_host_line,
    // sleep status to power control
    output logic sleep_mode,
    // busy indication
    output logic cmd_busy
);

    // ********************************************************************
    // storage
    // ********************************************************************
    logic [7:0] flash_mem [0:95]; // three 32-byte pages
    logic [7:0] ram_mem [0:31]; // general purpose ram

    // whole sequencer state sits in one registered struct
    fcs_state_s cur_q; // registered state
    fcs_state_s nxt_d; // next state

    logic [6:0] erase_addr; // byte being erased
    logic [7:0] prog_old; // addressed flash byte
    logic [7:0] flash_p0; // page 0 byte at index
    logic [7:0] ram_byte; // ram byte at index
    logic line_edge; // transition seen on host line

    // ********************************************************************
    // helpers
    // ********************************************************************
    // page base address for erase
    function automatic logic [6:0] page_base(input logic [1:0] page);
        page_base = {page, 5'h00};
    endfunction

    // register port address decode
    function automatic logic is_ofs(input logic [6:0] addr, input logic [6:0] ofs);
        is_ofs = (addr == ofs);
    endfunction

    // page base plus running index, pages never overlap
    assign erase_addr = page_base(cur_q.page) | {2'b00, cur_q.idx};
    // old byte read back for the and-programming
    assign prog_old = flash_mem[cur_q.prog_addr];
    assign flash_p0 = flash_mem[{2'b00, cur_q.idx}];
    assign ram_byte = ram_mem[cur_q.idx];
    // either polarity: synced level against its last copy
    assign line_edge = cur_q.line_sync[1] ^ cur_q.line_last;

    // ********************************************************************
    // next state
    // ********************************************************************
    // one copy of the state filled here, registered below
    always_comb
    begin
        nxt_d = cur_q;
        // pin synchronisers; first stage only feeds second stage
        nxt_d.line_sync = {cur_q.line_sync[0], single_wire_host_line};
        nxt_d.line_last = cur_q.line_sync[1];
        nxt_d.cond_sync = {cur_q.cond_sync[0], wake_cond_met};
        // RULE_11: sample quarter-kelvin temperature
        nxt_d.temp = die_temp_sample;
        nxt_d.rdata = 8'h00;

        // register reads, data valid next cycle
        // reads never stall the master
        if (reg_req.rd)
        begin
            if (is_ofs(reg_req.addr, `FCS_OFS_TEMP_LOW))
            begin
                // RULE_12: low byte of value
                nxt_d.rdata = cur_q.temp[7:0];
            end
            else if (is_ofs(reg_req.addr, `FCS_OFS_TEMP_HIGH))
            begin
                // RULE_13: reserved upper bits read zero
                nxt_d.rdata = {5'h00, cur_q.temp[10:8]};
            end
            else if (is_ofs(reg_req.addr, `FCS_OFS_CMD))
            begin
                nxt_d.rdata = cur_q.cmd;
            end
            else if (is_ofs(reg_req.addr, `FCS_OFS_PROG_ADDR))
            begin
                nxt_d.rdata = {1'b0, cur_q.prog_addr};
            end
            else if (is_ofs(reg_req.addr, `FCS_OFS_PROG_DATA))
            begin
                nxt_d.rdata = cur_q.prog_data;
            end
            else if (is_ofs(reg_req.addr, `FCS_OFS_WAKE_SEL))
            begin
                nxt_d.rdata = {5'h00, cur_q.wake_sel};
            end
            else if (is_ofs(reg_req.addr, `FCS_OFS_STATUS))
            begin
                nxt_d.rdata = {6'h00, cur_q.asleep, cur_q.state != FCS_IDLE};
            end
            else
            begin
                // unmapped reads zero
                nxt_d.rdata = 8'h00;
            end
        end

        // register writes; operand registers locked while busy
        // a pending command counts as busy, so it cannot be overwritten
        if (reg_req.wr && !cur_q.busy)
        begin
            if (is_ofs(reg_req.addr, `FCS_OFS_CMD))
            begin
                nxt_d.cmd = reg_req.wdata;
            end
            else if (is_ofs(reg_req.addr, `FCS_OFS_PROG_ADDR))
            begin
                nxt_d.prog_addr = reg_req.wdata[6:0];
            end
            else if (is_ofs(reg_req.addr, `FCS_OFS_PROG_DATA))
            begin
                nxt_d.prog_data = reg_req.wdata;
            end
            else if (is_ofs(reg_req.addr, `FCS_OFS_WAKE_SEL))
            begin
                nxt_d.wake_sel = reg_req.wdata[2:0];
            end
        end

        case (cur_q.state)
            FCS_IDLE:
            begin
                nxt_d.idx = 5'h00;
                // RULE_01: decode written command
                case (cur_q.cmd)
                    `FCS_CMD_PROG_BYTE: nxt_d.state = FCS_PROG;
                    // RULE_04: page 0 erase
                    `FCS_CMD_ERASE_P0:
                    begin
                        nxt_d.page = 2'h0;
                        nxt_d.state = FCS_ERASE;
                    end
                    // RULE_05: page 1 erase
                    `FCS_CMD_ERASE_P1:
                    begin
                        nxt_d.page = 2'h1;
                        nxt_d.state = FCS_ERASE;
                    end
                    // RULE_06: page 2 erase
                    `FCS_CMD_ERASE_P2:
                    begin
                        nxt_d.page = 2'h2;
                        nxt_d.state = FCS_ERASE;
                    end
                    `FCS_CMD_RAM_TO_FLASH: nxt_d.state = FCS_R2F;
                    `FCS_CMD_FLASH_TO_RAM: nxt_d.state = FCS_F2R;
                    `FCS_CMD_POWER_DOWN: nxt_d.state = FCS_WAIT_SLEEP;
                    // unknown code: drop it and stay idle
                    default:
                    begin
                        // a zero code is left alone so a fresh write lands
                        if (cur_q.cmd != 8'h00)
                        begin
                            nxt_d.cmd = 8'h00;
                        end
                    end
                endcase
            end
            FCS_PROG:
            begin
                // single-cycle operation, the array write happens below
                // RULE_02: done, clear command
                nxt_d.cmd = 8'h00;
                nxt_d.state = FCS_IDLE;
            end
            FCS_ERASE, FCS_R2F, FCS_F2R:
            begin
                // one byte per cycle over the page
                // index wraps to zero after the last byte
                nxt_d.idx = cur_q.idx + 5'h01;
                if (cur_q.idx == `FCS_PAGE_LAST)
                begin
                    // RULE_02: done, clear command
                    nxt_d.cmd = 8'h00;
                    nxt_d.state = FCS_IDLE;
                end
            end
            FCS_WAIT_SLEEP:
            begin
                // RULE_15: all-zero threshold sleeps at once
                // RULE_09: wait for wake condition
                // condition arrives through the two-flop synchroniser
                if (cur_q.wake_sel == 3'h0 || cur_q.cond_sync[1])
                begin
                    nxt_d.asleep = 1'b1;
                    nxt_d.state = FCS_SLEEP;
                end
            end
            FCS_SLEEP:
            begin
                // RULE_10: any host line edge wakes
                // waking also ends the power-down command
                if (line_edge)
                begin
                    nxt_d.asleep = 1'b0;
                    nxt_d.cmd = 8'h00;
                    nxt_d.state = FCS_IDLE;
                end
            end
            default: nxt_d.state = FCS_IDLE;
        endcase
        // busy kept in a flip-flop so the output needs no gate
        nxt_d.busy = (nxt_d.state != FCS_IDLE) || (nxt_d.cmd != 8'h00);
    end

    // ********************************************************************
    // state register
    // ********************************************************************
    // synchronous reset, active low
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            cur_q <= '0;
            cur_q.state <= FCS_IDLE;
            // RULE_15: thresholds reset to ones
            cur_q.wake_sel <= `FCS_WAKE_SEL_RESET;
            // host line idles high: detector starts there, no false wake
            cur_q.line_sync <= `FCS_LINE_SYNC_RESET;
            cur_q.line_last <= `FCS_LINE_LAST_RESET;
        end
        else
        begin
            cur_q <= nxt_d;
        end
    end

    // ********************************************************************
    // memory writes, no reset on arrays
    // ********************************************************************
    // outside erase, flash can only lose ones: programming ands into the old byte
    // arrays carry no reset, contents unknown until erased or written
    always_ff @(posedge core_clk)
    begin
        if (resetn && cur_q.state == FCS_PROG)
        begin
            // RULE_03: program can only clear bits
            flash_mem[cur_q.prog_addr] <= prog_old & cur_q.prog_data;
        end
        if (resetn && cur_q.state == FCS_ERASE)
        begin
            // RULE_04: erased bytes read all ones
            flash_mem[erase_addr] <= `FCS_ERASED_BYTE;
        end
        if (resetn && cur_q.state == FCS_R2F)
        begin
            // RULE_07: ram into page 0
            flash_mem[{2'b00, cur_q.idx}] <= flash_p0 & ram_byte;
        end
        if (resetn && cur_q.state == FCS_F2R)
        begin
            // RULE_08: page 0 into ram
            ram_mem[cur_q.idx] <= flash_p0;
        end
    end

    // ********************************************************************
    // outputs straight from flip-flops
    // ********************************************************************
    // read answer stands one cycle, then drops to zero
    assign reg_rdata = cur_q.rdata;
    assign sleep_mode = cur_q.asleep;
    // busy comes from its own flip-flop, not from gates
    assign cmd_busy = cur_q.busy;

endmodule // fcs_flash_sequencer

// ### rtl/fcs_pkg.sv
package fcs_pkg;
    // sequencer states
    typedef enum logic [2:0] {
        FCS_IDLE,
        FCS_PROG,
        FCS_ERASE,
        FCS_R2F,
        FCS_F2R,
        FCS_WAIT_SLEEP,
        FCS_SLEEP
    } fcs_state_e;

    // register port request
    typedef struct packed {
        logic [6:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } fcs_req_s;

    // whole state of the sequencer
    typedef struct packed {
        fcs_state_e state;
        logic [7:0] cmd;
        logic [6:0] prog_addr;
        logic [7:0] prog_data;
        logic [2:0] wake_sel;
        logic [1:0] page;
        logic [4:0] idx;
        logic [7:0] rdata;
        logic asleep;
        logic [1:0] line_sync;
        logic line_last;
        logic [1:0] cond_sync;
        logic [10:0] temp;
        logic busy;
    } fcs_state_s;
endpackage
